//--- rtl/pcts_pkg.sv
// Shared constants and types of the timer set.
package pcts_pkg;
    // ----------------------------------------------------------------
    // Widths and counts
    // ----------------------------------------------------------------
    localparam int PCTS_PSC_W = 16;
    localparam int PCTS_NARROW_W = 16;
    localparam int PCTS_WIDE_W = 32;
    localparam int PCTS_NCH = 4;
    localparam int PCTS_DT_W = 8;
    localparam int PCTS_NPAIR = 5;
    localparam int PCTS_NCAP = 10;
    localparam int PCTS_NTIM = 4;
    localparam int PCTS_NDT = 3;
    localparam int PCTS_NPAIR_ADV = 3;

    // ----------------------------------------------------------------
    // Modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PCTS_UP = 2'h0,
        PCTS_DOWN = 2'h1,
        PCTS_CENTER = 2'h2
    } pcts_dir_t;

    typedef enum logic [1:0] {
        PCTS_CH_CAP = 2'h0,
        PCTS_CH_TOGGLE = 2'h1,
        PCTS_CH_PWM = 2'h2,
        PCTS_CH_OFF = 2'h3
    } pcts_ch_t;

    typedef enum logic [1:0] {
        PCTS_TRG_NONE = 2'h0,
        PCTS_TRG_START = 2'h1,
        PCTS_TRG_GATE = 2'h2,
        PCTS_TRG_CHAIN = 2'h3
    } pcts_trg_t;
endpackage

//--- rtl/pcts_timer.sv
// One timer: prescaler, counter, trigger input and capture/compare channels.
`timescale 1ns/1ps
`default_nettype none
module pcts_timer #(
    parameter int W = 16,
    parameter int NCH = 1,
    parameter bit ENC = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    input wire logic freeze,
    input wire logic opm,
    input wire logic [1:0] dir_mode,
    input wire logic [pcts_pkg::PCTS_PSC_W-1:0] psc,
    input wire logic [W-1:0] arr,
    input wire logic [1:0] trg_mode,
    input wire logic trg_pulse,
    input wire logic trg_lvl,
    input wire logic enc_mode,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic [NCH-1:0][1:0] ch_mode,
    input wire logic [NCH-1:0][W-1:0] ccr,
    input wire logic [NCH-1:0] cap_in,
    input wire logic dma_en,
    input wire logic upd_clr,
    output logic [W-1:0] cnt_r,
    output logic upd_r,
    output logic upd_flag_r,
    output logic dma_req_r,
    output logic [NCH-1:0] ref_r,
    output logic [NCH-1:0][W-1:0] cap_val_r,
    output logic [NCH-1:0] cap_evt_r
);
    import pcts_pkg::*;
    logic [PCTS_PSC_W-1:0] psc_cnt_r;
    logic idle_r;
    logic up_r;
    logic enc_a_r;
    logic run;
    logic psc_tick;
    logic enc_on;
    logic tick;
    logic dn;
    logic wrap;
    logic [W-1:0] cnt_nxt;

    if (W < 2 || W > PCTS_WIDE_W || NCH < 1 || NCH > PCTS_NCH)
    begin : g_chk
        $error("pcts_timer: unsupported width or channel count.");
    end

    // ----------------------------------------------------------------
    // Tick generation
    // ----------------------------------------------------------------
    assign run = en && !freeze && !idle_r &&
        (trg_mode != PCTS_TRG_GATE || trg_lvl); // see RULE5
    assign psc_tick = run && psc_cnt_r == psc;
    assign enc_on = ENC && enc_mode;
    assign tick = enc_on ? (run && (enc_a ^ enc_a_r)) : // see RULE7
        (trg_mode == PCTS_TRG_CHAIN) ? (run && trg_pulse) : psc_tick;
    assign dn = enc_on ? (enc_a == enc_b) :
        (dir_mode == PCTS_DOWN) || (dir_mode == PCTS_CENTER && !up_r);
    assign wrap = tick && (dn ? cnt_r == '0 : cnt_r == arr);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            psc_cnt_r <= '0;
        else if (!run || psc_tick)
            psc_cnt_r <= '0;
        else
            psc_cnt_r <= psc_cnt_r + 1'b1; // see RULE1
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            idle_r <= 1'b0;
        else if (!en)
            idle_r <= trg_mode == PCTS_TRG_START;
        else if (wrap && opm)
            idle_r <= 1'b1; // see RULE3
        else if (trg_pulse && trg_mode == PCTS_TRG_START)
            idle_r <= 1'b0; // see RULE6
    end

    // ----------------------------------------------------------------
    // Counter and update event
    // ----------------------------------------------------------------
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (tick && !wrap)
            cnt_nxt = dn ? cnt_r - 1'b1 : cnt_r + 1'b1;
        else if (wrap && dir_mode == PCTS_CENTER && !enc_on)
            cnt_nxt = dn ? cnt_r + 1'b1 : cnt_r - 1'b1;
        else if (wrap)
            cnt_nxt = dn ? arr : '0; // see RULE10
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= '0;
            up_r <= 1'b1;
            enc_a_r <= 1'b0;
            upd_r <= 1'b0;
            dma_req_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt; // see RULE1
            enc_a_r <= enc_a;
            up_r <= (dir_mode != PCTS_CENTER) ? 1'b1 : (wrap ? dn : up_r);
            upd_r <= wrap; // see RULE9
            dma_req_r <= wrap && dma_en; // see RULE7
        end
    end

    // Set wins over clear so an update in the clearing cycle is kept.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            upd_flag_r <= 1'b0;
        else if (wrap)
            upd_flag_r <= 1'b1; // see RULE10
        else if (upd_clr)
            upd_flag_r <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
        logic cap_d_r;
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                cap_d_r <= 1'b0;
                ref_r[i] <= 1'b0;
                cap_val_r[i] <= '0;
                cap_evt_r[i] <= 1'b0;
            end
            else
            begin
                cap_d_r <= cap_in[i];
                cap_evt_r[i] <= 1'b0;
                unique case (pcts_ch_t'(ch_mode[i]))
                    PCTS_CH_CAP:
                    begin
                        ref_r[i] <= 1'b0;
                        if (cap_in[i] && !cap_d_r)
                        begin
                            cap_val_r[i] <= cnt_r; // see RULE8
                            cap_evt_r[i] <= 1'b1;
                        end
                    end
                    PCTS_CH_TOGGLE:
                        if (tick && cnt_r == ccr[i])
                            ref_r[i] <= !ref_r[i];
                    PCTS_CH_PWM:
                        ref_r[i] <= cnt_r < ccr[i]; // see RULE3
                    PCTS_CH_OFF:
                        ref_r[i] <= 1'b0; // see RULE9
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_wrap_up;
        tick && !enc_on && dir_mode == PCTS_UP && cnt_r == arr
            |=> cnt_r == '0 && upd_r && upd_flag_r;
    endproperty
    a_wrap_up: assert property (p_wrap_up) // see RULE10
        else $error("Counter did not restart after the reload value.");

    property p_tick_only;
        !tick |=> $stable(cnt_r);
    endproperty
    a_tick_only: assert property (p_tick_only) // see RULE1
        else $error("Counter moved without a tick.");

    property p_freeze;
        freeze |=> $stable(cnt_r) && !upd_r;
    endproperty
    a_freeze: assert property (p_freeze) // see RULE5
        else $error("Counter moved while frozen.");

    property p_dma;
        dma_req_r |-> upd_r && $past(dma_en);
    endproperty
    a_dma: assert property (p_dma) // see RULE7
        else $error("DMA request without an enabled update.");

    property p_cap;
        cap_evt_r[0] |-> cap_val_r[0] == $past(cnt_r) &&
            $past(ch_mode[0]) == PCTS_CH_CAP;
    endproperty
    a_cap: assert property (p_cap) // see RULE8
        else $error("Captured value differs from the counter.");

    property p_pwm_zero;
        ch_mode[0] == PCTS_CH_PWM && ccr[0] == '0 |=> !ref_r[0];
    endproperty
    a_pwm_zero: assert property (p_pwm_zero) // see RULE3
        else $error("Zero duty produced a high output.");

    property p_tbase;
        (ch_mode[0] == PCTS_CH_OFF) [*2] |-> !ref_r[0];
    endproperty
    a_tbase: assert property (p_tbase) // see RULE9
        else $error("Time-base channel drove its output.");

    c_wrap: cover property (upd_r);
    c_cap: cover property (cap_evt_r[0]);
endmodule // pcts_timer
`default_nettype wire

//--- rtl/pcts_timer_set.sv
// Timer set: advanced PWM timer, wide timer and two small timers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: Small timers: 16-bit upcounter, reload, 16-bit prescaler.
// RULE2: Advanced timer: three complementary pairs with dead time.
// RULE3: Four channels: capture, compare, PWM, one-pulse.
// RULE4: Debug halt freezes counter, forces outputs off.
// RULE5: General timers may freeze counter in debug.
// RULE6: Advanced and wide timers trigger each other.
// RULE7: Wide timer: own DMA requests, quadrature counting.
// RULE8: Small timers: one channel plus complementary output.
// RULE9: Any timer works as a plain time base.
// RULE10: Reload reached: restart, update event, flag, DMA.
module pcts_timer_set #(
    parameter int DT_W = pcts_pkg::PCTS_DT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [pcts_pkg::PCTS_NTIM-1:0] en,
    input wire logic [pcts_pkg::PCTS_NTIM-1:0] opm,
    input wire logic [pcts_pkg::PCTS_NTIM-1:0] dbg_freeze,
    input wire logic [pcts_pkg::PCTS_NTIM-1:0] dma_en,
    input wire logic [pcts_pkg::PCTS_NTIM-1:0] upd_clr,
    input wire logic dbg_halt,
    input wire logic dbg_kill,
    input wire logic [pcts_pkg::PCTS_NTIM-1:0][1:0] dir_mode,
    input wire logic [pcts_pkg::PCTS_NTIM-1:0][pcts_pkg::PCTS_PSC_W-1:0] psc,
    input wire logic [pcts_pkg::PCTS_NTIM-1:0][pcts_pkg::PCTS_WIDE_W-1:0] arr,
    input wire logic [1:0][1:0] trg_mode,
    input wire logic enc_mode,
    input wire logic enc_a_pin,
    input wire logic enc_b_pin,
    input wire logic [pcts_pkg::PCTS_NCH-1:0][1:0] adv_ch_mode,
    input wire logic [pcts_pkg::PCTS_NCH-1:0][pcts_pkg::PCTS_NARROW_W-1:0]
        adv_ccr,
    input wire logic [pcts_pkg::PCTS_NCH-1:0][1:0] wide_ch_mode,
    input wire logic [pcts_pkg::PCTS_NCH-1:0][pcts_pkg::PCTS_WIDE_W-1:0]
        wide_ccr,
    input wire logic [1:0][1:0] small_ch_mode,
    input wire logic [1:0][pcts_pkg::PCTS_NARROW_W-1:0] small_ccr,
    input wire logic [pcts_pkg::PCTS_NDT-1:0][DT_W-1:0] dead_time,
    input wire logic [pcts_pkg::PCTS_NCAP-1:0] cap_pin,
    output logic [pcts_pkg::PCTS_NTIM-1:0] upd_flag,
    output logic [pcts_pkg::PCTS_NTIM-1:0] dma_req,
    output logic [pcts_pkg::PCTS_NARROW_W-1:0] adv_cnt,
    output logic [pcts_pkg::PCTS_WIDE_W-1:0] wide_cnt,
    output logic [pcts_pkg::PCTS_NARROW_W-1:0] sa_cnt,
    output logic [pcts_pkg::PCTS_NARROW_W-1:0] sb_cnt,
    output logic [pcts_pkg::PCTS_NCH-1:0][pcts_pkg::PCTS_NARROW_W-1:0] adv_cap,
    output logic [pcts_pkg::PCTS_NCH-1:0][pcts_pkg::PCTS_WIDE_W-1:0] wide_cap,
    output logic [pcts_pkg::PCTS_NARROW_W-1:0] sa_cap,
    output logic [pcts_pkg::PCTS_NARROW_W-1:0] sb_cap,
    output logic [pcts_pkg::PCTS_NCAP-1:0] cap_evt,
    output logic [pcts_pkg::PCTS_NPAIR-1:0] pwm_out,
    output logic [pcts_pkg::PCTS_NPAIR-1:0] pwm_out_n,
    output logic adv_oc4_r,
    output logic [pcts_pkg::PCTS_NCH-1:0] wide_oc
);
    import pcts_pkg::*;
    logic [PCTS_NCAP+1:0] sync1_r;
    logic [PCTS_NCAP+1:0] sync2_r;
    logic [PCTS_NTIM-1:0] frz;
    logic [PCTS_NTIM-1:0] upd;
    logic [PCTS_NTIM-1:0] upf;
    logic [PCTS_NTIM-1:0] dmq;
    logic [PCTS_NCH-1:0] adv_ref;
    logic [PCTS_NCH-1:0] adv_evt;
    logic [PCTS_NCH-1:0] wide_evt;
    logic sa_ref;
    logic sb_ref;
    logic sa_evt;
    logic sb_evt;
    logic kill;
    logic [PCTS_NPAIR-1:0] pair_ref;

    if (DT_W < 1 || DT_W > PCTS_NARROW_W)
    begin : g_chk
        $error("pcts_timer_set: unsupported dead-time width.");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Capture and encoder pins are asynchronous; only the second stage
    // is ever read.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= {enc_b_pin, enc_a_pin, cap_pin};
            sync2_r <= sync1_r;
        end
    end

    assign frz = {PCTS_NTIM{dbg_halt}} & dbg_freeze; // see RULE4
    assign kill = dbg_halt && dbg_kill;
    assign upd_flag = upf;
    assign dma_req = dmq;
    assign cap_evt = {sb_evt, sa_evt, wide_evt, adv_evt};

    // ----------------------------------------------------------------
    // Timers
    // ----------------------------------------------------------------
    // The two large timers feed each other's trigger input.
    pcts_timer #(.W(PCTS_NARROW_W), .NCH(PCTS_NCH), .ENC(1'b0)) u_adv (
        .clk(clk),
        .rst_n(rst_n),
        .en(en[0]),
        .freeze(frz[0]),
        .opm(opm[0]),
        .dir_mode(dir_mode[0]),
        .psc(psc[0]),
        .arr(arr[0][PCTS_NARROW_W-1:0]),
        .trg_mode(trg_mode[0]),
        .trg_pulse(upd[1]), // see RULE6
        .trg_lvl(wide_oc[0]),
        .enc_mode(1'b0),
        .enc_a(1'b0),
        .enc_b(1'b0),
        .ch_mode(adv_ch_mode),
        .ccr(adv_ccr),
        .cap_in(sync2_r[3:0]),
        .dma_en(dma_en[0]),
        .upd_clr(upd_clr[0]),
        .cnt_r(adv_cnt),
        .upd_r(upd[0]),
        .upd_flag_r(upf[0]),
        .dma_req_r(dmq[0]),
        .ref_r(adv_ref),
        .cap_val_r(adv_cap),
        .cap_evt_r(adv_evt)
    );

    pcts_timer #(.W(PCTS_WIDE_W), .NCH(PCTS_NCH), .ENC(1'b1)) u_wide (
        .clk(clk),
        .rst_n(rst_n),
        .en(en[1]),
        .freeze(frz[1]),
        .opm(opm[1]),
        .dir_mode(dir_mode[1]),
        .psc(psc[1]),
        .arr(arr[1]),
        .trg_mode(trg_mode[1]),
        .trg_pulse(upd[0]), // see RULE6
        .trg_lvl(adv_ref[0]),
        .enc_mode(enc_mode),
        .enc_a(sync2_r[PCTS_NCAP]), // see RULE7
        .enc_b(sync2_r[PCTS_NCAP+1]),
        .ch_mode(wide_ch_mode),
        .ccr(wide_ccr),
        .cap_in(sync2_r[7:4]),
        .dma_en(dma_en[1]),
        .upd_clr(upd_clr[1]),
        .cnt_r(wide_cnt),
        .upd_r(upd[1]),
        .upd_flag_r(upf[1]),
        .dma_req_r(dmq[1]),
        .ref_r(wide_oc),
        .cap_val_r(wide_cap),
        .cap_evt_r(wide_evt)
    );

    pcts_timer #(.W(PCTS_NARROW_W), .NCH(1), .ENC(1'b0)) u_sa (
        .clk(clk),
        .rst_n(rst_n),
        .en(en[2]),
        .freeze(frz[2]),
        .opm(opm[2]),
        .dir_mode(dir_mode[2]),
        .psc(psc[2]),
        .arr(arr[2][PCTS_NARROW_W-1:0]),
        .trg_mode(PCTS_TRG_NONE),
        .trg_pulse(1'b0),
        .trg_lvl(1'b0),
        .enc_mode(1'b0),
        .enc_a(1'b0),
        .enc_b(1'b0),
        .ch_mode(small_ch_mode[0]),
        .ccr(small_ccr[0]),
        .cap_in(sync2_r[8]),
        .dma_en(dma_en[2]),
        .upd_clr(upd_clr[2]),
        .cnt_r(sa_cnt),
        .upd_r(upd[2]),
        .upd_flag_r(upf[2]),
        .dma_req_r(dmq[2]),
        .ref_r(sa_ref),
        .cap_val_r(sa_cap),
        .cap_evt_r(sa_evt)
    );

    pcts_timer #(.W(PCTS_NARROW_W), .NCH(1), .ENC(1'b0)) u_sb (
        .clk(clk),
        .rst_n(rst_n),
        .en(en[3]),
        .freeze(frz[3]),
        .opm(opm[3]),
        .dir_mode(dir_mode[3]),
        .psc(psc[3]),
        .arr(arr[3][PCTS_NARROW_W-1:0]),
        .trg_mode(PCTS_TRG_NONE),
        .trg_pulse(1'b0),
        .trg_lvl(1'b0),
        .enc_mode(1'b0),
        .enc_a(1'b0),
        .enc_b(1'b0),
        .ch_mode(small_ch_mode[1]),
        .ccr(small_ccr[1]),
        .cap_in(sync2_r[9]),
        .dma_en(dma_en[3]),
        .upd_clr(upd_clr[3]),
        .cnt_r(sb_cnt),
        .upd_r(upd[3]),
        .upd_flag_r(upf[3]),
        .dma_req_r(dmq[3]),
        .ref_r(sb_ref),
        .cap_val_r(sb_cap),
        .cap_evt_r(sb_evt)
    );

    // ----------------------------------------------------------------
    // Dead time and output shutdown
    // ----------------------------------------------------------------
    // Any change of the reference drops both outputs first, so the pair
    // is never on together; the gap is dead_time + 1 cycles.
    assign pair_ref = {sb_ref, sa_ref, adv_ref[PCTS_NPAIR_ADV-1:0]};

    for (genvar k = 0; k < PCTS_NPAIR; k++)
    begin : g_dt
        localparam int SEL = (k < PCTS_NPAIR_ADV) ? 0 : k - 2;
        logic ref_d_r;
        logic [DT_W-1:0] dt_cnt_r;
        logic hold;
        logic off;
        assign hold = pair_ref[k] != ref_d_r || dt_cnt_r != '0;
        assign off = kill && (k < PCTS_NPAIR_ADV);
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                ref_d_r <= 1'b0;
                dt_cnt_r <= '0;
                pwm_out[k] <= 1'b0;
                pwm_out_n[k] <= 1'b0;
            end
            else
            begin
                ref_d_r <= pair_ref[k];
                if (pair_ref[k] != ref_d_r)
                    dt_cnt_r <= dead_time[SEL]; // see RULE2
                else if (dt_cnt_r != '0)
                    dt_cnt_r <= dt_cnt_r - 1'b1;
                pwm_out[k] <= !off && !hold && pair_ref[k]; // see RULE4
                pwm_out_n[k] <= !off && !hold && !pair_ref[k]; // see RULE8
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            adv_oc4_r <= 1'b0;
        else
            adv_oc4_r <= !kill && adv_ref[3]; // see RULE4
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_dead;
        $rose(pwm_out[0]) |-> !$past(pwm_out_n[0]) && !pwm_out_n[0];
    endproperty
    a_dead: assert property (p_dead) // see RULE2
        else $error("Main output rose without a dead-time gap.");

    property p_kill;
        kill |=> pwm_out[PCTS_NPAIR_ADV-1:0] == '0 &&
            pwm_out_n[PCTS_NPAIR_ADV-1:0] == '0 && !adv_oc4_r;
    endproperty
    a_kill: assert property (p_kill) // see RULE4
        else $error("Advanced outputs active during debug shutdown.");

    property p_chain;
        trg_mode[0] == PCTS_TRG_CHAIN && $stable(trg_mode[0]) &&
            $changed(adv_cnt) |-> $past(upd[1]);
    endproperty
    a_chain: assert property (p_chain) // see RULE6
        else $error("Chained advanced counter moved without an update.");

    c_dead: cover property ($rose(pwm_out[0]));
    c_kill: cover property (kill && $past(pwm_out[0]));
endmodule // pcts_timer_set
`default_nettype wire

//--- test/pcts_pin_model.sv
// Pin-side model: capture signal sources and a quadrature encoder.
`timescale 1ns/1ps
`default_nettype none
module pcts_pin_model (
    input wire logic clk,
    output logic [pcts_pkg::PCTS_NCAP-1:0] cap_pin,
    output logic enc_a_pin,
    output logic enc_b_pin
);
    import pcts_pkg::*;
    // ----------------------------------------------------------------
    // Sources
    // ----------------------------------------------------------------
    initial
    begin
        cap_pin = '0;
        enc_a_pin = 1'b0;
        enc_b_pin = 1'b0;
    end
    // The pulse lasts six clocks so that the two-flop synchroniser
    // cannot miss it, as a slow sensor edge would behave.
    task automatic cap_pulse(input int idx);
        @(negedge clk);
        cap_pin[idx] = 1'b1;
        repeat (6) @(negedge clk);
        cap_pin[idx] = 1'b0;
    endtask
    // B settles well before A moves, so direction is never ambiguous.
    task automatic enc_step(input logic a, input logic b);
        @(negedge clk);
        enc_b_pin = b;
        repeat (4) @(negedge clk);
        enc_a_pin = a;
        repeat (6) @(negedge clk);
    endtask
endmodule // pcts_pin_model
`default_nettype wire

//--- test/pcts_timer_set_tb.sv
// Self-checking bench for the timer set and its pin sources.
`timescale 1ns/1ps
`default_nettype none
module pcts_timer_set_tb;
    import pcts_pkg::*;
    logic clk, rst_n, dbg_halt, dbg_kill, enc_mode, adv_oc4_r;
    logic [PCTS_NTIM-1:0] en, opm, dbg_freeze, dma_en, upd_clr;
    logic [PCTS_NTIM-1:0] upd_flag, dma_req;
    logic [PCTS_NTIM-1:0][1:0] dir_mode;
    logic [PCTS_NTIM-1:0][PCTS_PSC_W-1:0] psc;
    logic [PCTS_NTIM-1:0][PCTS_WIDE_W-1:0] arr;
    logic [1:0][1:0] trg_mode, small_ch_mode;
    logic [PCTS_NCH-1:0][1:0] adv_ch_mode, wide_ch_mode;
    logic [PCTS_NCH-1:0][PCTS_NARROW_W-1:0] adv_ccr, adv_cap;
    logic [PCTS_NCH-1:0][PCTS_WIDE_W-1:0] wide_ccr, wide_cap;
    logic [1:0][PCTS_NARROW_W-1:0] small_ccr;
    logic [PCTS_NDT-1:0][PCTS_DT_W-1:0] dead_time;
    logic [PCTS_NCAP-1:0] cap_pin, cap_evt;
    logic enc_a_pin, enc_b_pin;
    logic [PCTS_NARROW_W-1:0] adv_cnt, sa_cnt, sb_cnt, sa_cap, sb_cap;
    logic [PCTS_WIDE_W-1:0] wide_cnt;
    logic [PCTS_NPAIR-1:0] pwm_out, pwm_out_n;
    logic [PCTS_NCH-1:0] wide_oc;
    int err_total, compares, i, n;

    pcts_timer_set uut (
        .clk, .rst_n, .en, .opm, .dbg_freeze, .dma_en, .upd_clr,
        .dbg_halt, .dbg_kill, .dir_mode, .psc, .arr, .trg_mode,
        .enc_mode, .enc_a_pin, .enc_b_pin, .adv_ch_mode, .adv_ccr,
        .wide_ch_mode, .wide_ccr, .small_ch_mode, .small_ccr,
        .dead_time, .cap_pin, .upd_flag, .dma_req, .adv_cnt,
        .wide_cnt, .sa_cnt, .sb_cnt, .adv_cap, .wide_cap, .sa_cap,
        .sb_cap, .cap_evt, .pwm_out, .pwm_out_n, .adv_oc4_r, .wide_oc
    );
    pcts_pin_model pins (.clk, .cap_pin, .enc_a_pin, .enc_b_pin);

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, exp, input string m);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic print_verdict;
        $display("compares %0d, err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic hang(input string m);
        chk(1'b0, 1'b1, m);
        print_verdict();
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    // Every timer is left off with its channels off, so each test
    // starts from a known quiet state.
    task automatic do_reset;
        if ($time > 0)
            @(negedge clk);
        rst_n = 1'b0;
        {en, opm, dbg_freeze, dma_en, upd_clr} = '0;
        {dbg_halt, dbg_kill, enc_mode, dir_mode, psc, arr} = '0;
        {trg_mode, adv_ccr, wide_ccr, small_ccr, dead_time} = '0;
        {adv_ch_mode, wide_ch_mode, small_ch_mode} = '1;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_timebase;
        arr[2] = 32'hFFFF_0003;
        dma_en[2] = 1'b1;
        en[2] = 1'b1;
        for (i = 0; i < 20 && sa_cnt !== 16'h0003; i++)
            cyc(1);
        if (i == 20)
            hang("wrap");
        cyc(1);
        chk(sa_cnt, 32'h0, "wrap");
        chk({upd_flag[2], dma_req[2]}, 32'h3, "update");
        cyc(1);
        chk({sa_cnt, dma_req[2]}, 32'h2, "dma");
        @(negedge clk);
        en[2] = 1'b0;
        upd_clr[2] = 1'b1;
        psc[2] = 16'h0002;
        cyc(2);
        chk(upd_flag[2], 32'h0, "clear");
        @(negedge clk);
        upd_clr[2] = 1'b0;
        en[2] = 1'b1;
        for (i = 0; i < 20 && sa_cnt === 16'h0001; i++)
            cyc(1);
        for (i = 0; i < 20 && sa_cnt === 16'h0002; i++)
            cyc(1);
        chk(i, 32'h3, "prescale");
        @(negedge clk);
        {opm[3], en[3]} = 2'h3;
        arr[3] = 32'h3;
        cyc(12);
        chk({sb_cnt, upd_flag[3]}, 32'h1, "one pulse");
    endtask
    task automatic test_debug;
        logic [31:0] a, w, s;
        adv_ch_mode = {4{2'h2}};
        adv_ccr = {4{16'h0004}};
        arr = {32'h63, 32'h63, 32'h63, 32'h9};
        dbg_freeze = 4'h3;
        en = 4'hB;
        cyc(20);
        @(negedge clk);
        {dbg_halt, dbg_kill} = 2'h3;
        cyc(1);
        chk({pwm_out[2:0], pwm_out_n[2:0], adv_oc4_r}, 32'h0, "kill");
        a = adv_cnt;
        w = wide_cnt;
        s = sb_cnt;
        cyc(8);
        chk(adv_cnt, a, "adv frozen");
        chk(wide_cnt, w, "wide frozen");
        chk(sb_cnt != s, 32'h1, "sb runs");
        @(negedge clk);
        {dbg_halt, dbg_kill} = 2'h0;
        cyc(3);
        chk(adv_cnt != a, 32'h1, "resume");
    endtask
    // Forty cycles are four whole periods, so the duty sum is exact.
    task automatic watch_pair(input int p);
        int lo, hi;
        lo = -99;
        hi = 0;
        repeat (40)
        begin
            cyc(1);
            chk(pwm_out[p] & pwm_out_n[p], 32'h0, "overlap");
            if (pwm_out[p] | pwm_out_n[p])
            begin
                if (lo > 0)
                    chk(lo, 32'h3, "dead time");
                lo = 0;
            end
            else
                lo++;
            hi += (pwm_out[p] === 1'b1);
        end
        chk(hi, 32'h8, "duty");
    endtask
    task automatic test_deadtime;
        {adv_ch_mode, small_ch_mode} = {6{2'h2}};
        adv_ccr = {16'h0005, 16'h00FF, 16'h0000, 16'h0005};
        small_ccr = {2{16'h0005}};
        arr = {4{32'h9}};
        dead_time = {3{8'h02}};
        en = 4'hD;
        cyc(15);
        chk({pwm_out[2:1], pwm_out_n[2:1]}, 32'h9, "full");
        watch_pair(0);
        watch_pair(3);
        watch_pair(4);
    endtask
    task automatic cap_check(input int idx);
        n = 0;
        fork
            pins.cap_pulse(idx);
            repeat (12)
            begin
                cyc(1);
                n += (cap_evt[idx] === 1'b1);
            end
        join
        chk(n, 32'h1, "cap pulse");
    endtask
    task automatic test_capture;
        {adv_ch_mode, small_ch_mode} = '0;
        arr = {4{32'h63}};
        en = 4'h5;
        for (i = 0; i < 20 && sa_cnt !== 16'h0005; i++)
            cyc(1);
        if (i == 20)
            hang("count");
        @(negedge clk);
        en = 4'h0;
        cap_check(0);
        cap_check(8);
        chk({adv_cap[0], sa_cap}, 32'h0005_0005, "cap val");
    endtask
    task automatic test_encoder;
        enc_mode = 1'b1;
        arr[1] = 32'hFFFF;
        en[1] = 1'b1;
        for (i = 0; i < 4; i++)
            pins.enc_step(~i[0], i[0]);
        chk(wide_cnt, 32'h4, "forward");
        pins.enc_step(1'b1, 1'b1);
        pins.enc_step(1'b0, 1'b0);
        chk(wide_cnt, 32'h2, "reverse");
    endtask
    task automatic test_trigger;
        trg_mode[0] = 2'h1;
        arr = {32'h0, 32'h0, 32'h3, 32'h3E7};
        @(negedge clk) en[0] = 1'b1;
        cyc(8);
        chk(adv_cnt, 32'h0, "idle");
        @(negedge clk);
        en[1] = 1'b1;
        cyc(10);
        chk(adv_cnt != 0, 32'h1, "started");
        do_reset();
        trg_mode[0] = 2'h3;
        arr = {32'h0, 32'h0, 32'h3, 32'h3E7};
        dma_en[1] = 1'b1;
        en = 4'h3;
        n = 0;
        for (i = 0; i < 46; i++)
        begin
            cyc(1);
            n += (dma_req[1] === 1'b1);
            if (i == 39)
                @(negedge clk) en[1] = 1'b0;
        end
        chk(n > 8, 32'h1, "wide dma");
        chk(adv_cnt, n, "chain");
    endtask

    initial
    begin
        err_total = 0;
        compares = 0;
        do_reset();
        test_timebase();
        $display("timebase done");
        do_reset();
        test_debug();
        $display("debug done");
        do_reset();
        test_deadtime();
        $display("dead time done");
        do_reset();
        test_capture();
        $display("capture done");
        do_reset();
        test_encoder();
        $display("encoder done");
        do_reset();
        test_trigger();
        $display("trigger done");
        print_verdict();
    end
endmodule // pcts_timer_set_tb
`default_nettype wire
